// ===== inc/mcsf_pkg.sv
// package: register map, reset values and timing constants of the motion status flag bank
package mcsf_pkg;
   // register byte offsets (word aligned)
   localparam logic [7:0]  MCSF_FLAGS_OFS     = 8'h00;
   localparam logic [7:0]  MCSF_CTRL_OFS      = 8'h04;
   localparam logic [7:0]  MCSF_IRQ_STAT_OFS  = 8'h08;
   localparam logic [7:0]  MCSF_IRQ_MASK_OFS  = 8'h0C;
   localparam logic [7:0]  MCSF_TEST_ERR_OFS  = 8'h10;
   localparam logic [7:0]  MCSF_WDT_CAUSE_OFS = 8'h14;
   localparam logic [7:0]  MCSF_MULTI_ERR_OFS = 8'h18;
   // bit positions of the flags word
   localparam int MCSF_B_CPU4_RST   = 0;
   localparam int MCSF_B_CPU_ERR    = 1;   // bits 1..4 for cpus 1..4
   localparam int MCSF_B_ONE        = 5;
   localparam int MCSF_B_ZERO       = 6;
   localparam int MCSF_B_READY      = 7;
   localparam int MCSF_B_TEST       = 8;
   localparam int MCSF_B_TEST_ERR   = 9;
   localparam int MCSF_B_FSTOP_IN   = 10;
   localparam int MCSF_B_SCOPE      = 11;
   localparam int MCSF_B_CAM        = 12;
   localparam int MCSF_B_FSTOP_LAT  = 13;
   localparam int MCSF_B_AMPLESS    = 14;
   localparam int MCSF_B_WDT        = 15;
   localparam int MCSF_NFLAGS       = 16;
   // control word bits
   localparam int MCSF_C_CLR_LATCH  = 0;   // write one clears forced-stop latch
   localparam int MCSF_C_CLR_TEST   = 1;   // write one clears test request error
   localparam int MCSF_C_CLR_WDT    = 2;   // write one clears watchdog error
   // interrupt event bits
   localparam int MCSF_I_READY      = 0;
   localparam int MCSF_I_TEST_ERR   = 1;
   localparam int MCSF_I_FSTOP      = 2;
   localparam int MCSF_I_WDT        = 3;
   localparam int MCSF_I_CPU_DOWN   = 4;
   localparam int MCSF_NIRQ         = 5;
   localparam logic [15:0] MCSF_MULTI_DOWN_CODE = 16'h1B58;  // 7000 decimal
   localparam logic [15:0] MCSF_WORD_RST        = 16'h0000;
   // operation cycle and main processing periods
   localparam int MCSF_CLK_HZ       = 10_000_000;
   localparam int MCSF_OPCYC_US     = 888;
   localparam int MCSF_OPCYC_CYC    = (MCSF_CLK_HZ / 1_000_000) * MCSF_OPCYC_US;
   localparam int MCSF_MAIN_US      = 100;
   localparam int MCSF_MAIN_CYC     = (MCSF_CLK_HZ / 1_000_000) * MCSF_MAIN_US;
   localparam int MCSF_SYNC_W       = 13;
endpackage : mcsf_pkg

// ===== inc/mcsf_sync_if.sv
// interface: raw asynchronous inputs and their filtered copies
`timescale 1ns/1ps
interface mcsf_sync_if;
   logic [mcsf_pkg::MCSF_SYNC_W-1:0] raw;
   logic [mcsf_pkg::MCSF_SYNC_W-1:0] clean;
   modport src (output raw, input clean);
   modport snk (input raw, output clean);
endinterface : mcsf_sync_if

// ===== sim/mcsf_chk.sv
// checker: port timing of the motion status flag bank
`timescale 1ns/1ps
module mcsf_chk (
   input wire logic        sys_clk_i,
   input wire logic        rst_b_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic        cpu4_in_reset_i,
   input wire logic        multi_cpu_down_o,
   input wire logic        host_ready_request_i,
   input wire logic        param_check_start_o,
   input wire logic        processor_ready_o,
   input wire logic        watchdog_error_i,
   input wire logic        axes_immediate_stop_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_down_held;
      cpu4_in_reset_i [*8];
   endsequence
   sequence s_up_held;
      !cpu4_in_reset_i [*8];
   endsequence
   ////////////////////////////////////////
   a_ack_answer: assert property (s_req |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data not zero outside ack");
   a_down_set: assert property (s_down_held |-> multi_cpu_down_o)
      else $error("cpu down not reported");
   a_down_clear: assert property (s_up_held |-> !multi_cpu_down_o)
      else $error("cpu down reported after release");
   a_check_start: assert property ($rose(host_ready_request_i) |-> ##2 param_check_start_o)
      else $error("parameter check not started");
   a_start_pulse: assert property (param_check_start_o |=> !param_check_start_o)
      else $error("check start longer than one cycle");
   a_ready_cause: assert property ($rose(processor_ready_o) |-> $past(host_ready_request_i))
      else $error("ready without request");
   a_ready_drop: assert property ($fell(host_ready_request_i) |-> ##2 !processor_ready_o)
      else $error("ready kept after request dropped");
   a_wdt_stop: assert property ($rose(watchdog_error_i) |-> ##2 axes_immediate_stop_o)
      else $error("axes not stopped on watchdog");
endmodule : mcsf_chk

bind mcsf_top mcsf_chk u_chk (.sys_clk_i, .rst_b_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o,
   .cpu4_in_reset_i, .multi_cpu_down_o, .host_ready_request_i, .param_check_start_o,
   .processor_ready_o, .watchdog_error_i, .axes_immediate_stop_o);

// ===== sim/mcsf_host_model.sv
// host-side model: answers a parameter check start after a set delay
`timescale 1ns/1ps
module mcsf_host_model (
   input  wire logic       sys_clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       start_i,
   input  wire logic       fail_i,
   input  wire logic [3:0] delay_i,
   output logic            done_o,
   output logic            err_o
);
   logic [3:0] cnt_q;
   logic       busy_q;
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         busy_q <= 1'b0;
         cnt_q  <= 4'h0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            busy_q <= 1'b1;
            cnt_q  <= delay_i;
         end else if (busy_q && cnt_q == 4'h0) begin
            busy_q <= 1'b0;
            done_o <= 1'b1;
         end else if (busy_q) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
   // verdict means nothing without done, so show the opposite there
   assign err_o = done_o ? fail_i : ~fail_i;
endmodule : mcsf_host_model

// ===== sim/tb.sv
// testbench: register reads of the status flag bank against its inputs
`timescale 1ns/1ps
module tb;
   import mcsf_pkg::*;
   logic sys_clk_i = 1'b0, rst_b_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [3:0] wb_sel_i = 4'h0, cpu_stop_error_i = 4'h0, dly = 4'h0;
   logic cpu4_in_reset_i = 1'b0, forced_stop_b_i = 1'b1, host_ready_request_i = 1'b0, fail = 1'b0;
   logic test_mode_request_i = 1'b0, test_mode_established_i = 1'b0, test_mode_failed_i = 1'b0;
   logic scope_running_i = 1'b0, cam_write_op_i = 1'b0, cam_open_area_write_op_i = 1'b0;
   logic cam_autogen_op_i = 1'b0, amp_less_mode_i = 1'b0, watchdog_error_i = 1'b0;
   logic [15:0] test_fail_low_i = 16'h0000, test_fail_high_i = 16'h0000, watchdog_cause_i = 16'h0000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, irq_o, param_check_start_o, axes_immediate_stop_o, processor_ready_o;
   logic multi_cpu_down_o, param_check_done_i, param_check_error_i;
   int n_errors = 0, compares = 0, cycles = 0;
   always #50 sys_clk_i = ~sys_clk_i;
   mcsf_top dut (.sys_clk_i, .rst_b_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
      .wb_dat_o, .wb_ack_o, .irq_o, .cpu4_in_reset_i, .cpu_stop_error_i, .forced_stop_b_i,
      .host_ready_request_i, .param_check_done_i, .param_check_error_i, .test_mode_request_i,
      .test_mode_established_i, .test_mode_failed_i, .test_fail_low_i, .test_fail_high_i,
      .scope_running_i, .cam_write_op_i, .cam_open_area_write_op_i, .cam_autogen_op_i,
      .amp_less_mode_i, .watchdog_error_i, .watchdog_cause_i, .param_check_start_o,
      .axes_immediate_stop_o, .processor_ready_o, .multi_cpu_down_o);
   mcsf_host_model host (.sys_clk_i, .rst_b_i, .start_i(param_check_start_o), .fail_i(fail),
      .delay_i(dly), .done_o(param_check_done_i), .err_o(param_check_error_i));
   ////////////////////////////////////////
   task automatic summarize();
      if (n_errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : cyc
   // one classic cycle, held until ack is sampled high
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
      @(posedge sys_clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do @(posedge sys_clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, 4'hF, q);
      chk(nm, e, q);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      logic [31:0] q;
      bus(1'b1, a, d, s, q);
   endtask : wr
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         n_errors++;
         summarize();
      end
   end
   initial begin
      cyc(20);
      rst_b_i <= 1'b1;
      rd(MCSF_FLAGS_OFS, 32'h0000_0C20, "flags_rst");
      rd(8'h1C, 32'h0000_0000, "unmapped");
      cpu4_in_reset_i <= 1'b1;
      cpu_stop_error_i <= 4'hA;
      {test_mode_request_i, test_mode_established_i, scope_running_i} <= 3'b111;
      {cam_write_op_i, amp_less_mode_i} <= 2'b11;
      // amp-less flag only follows its input on the main processing enable
      cyc(MCSF_MAIN_CYC + 1);
      rd(MCSF_FLAGS_OFS, 32'h0000_5535, "flags_set");
      rd(MCSF_MULTI_ERR_OFS, 32'h0000_1B58, "down_code");
      {cpu4_in_reset_i, cpu_stop_error_i, test_mode_established_i, scope_running_i} <= 7'h00;
      {test_mode_request_i, cam_write_op_i, amp_less_mode_i} <= 3'b000;
      cyc(MCSF_MAIN_CYC + 1);
      for (int i = 0; i < 4; i++) begin
         {cam_autogen_op_i, cam_open_area_write_op_i, cam_write_op_i} <= 3'b001 << i;
         cyc(8);
         rd(MCSF_FLAGS_OFS, (i < 3) ? 32'h0000_1C20 : 32'h0000_0C20, "cam");
      end
      wr(MCSF_IRQ_MASK_OFS, 32'h0000_0001);
      fail <= 1'b1;
      host_ready_request_i <= 1'b1;
      cyc(12);
      chk("ready_bad", 32'h0, {31'h0, processor_ready_o});
      host_ready_request_i <= 1'b0;
      cyc(3);
      fail <= 1'b0;
      dly <= 4'hA;
      host_ready_request_i <= 1'b1;
      // host waits for ready before using the device
      for (int i = 0; i < 40 && processor_ready_o !== 1'b1; i++) cyc(1);
      rd(MCSF_FLAGS_OFS, 32'h0000_0CA0, "ready_flag");
      chk("irq_on", 32'h1, {31'h0, irq_o});
      rd(MCSF_IRQ_STAT_OFS, 32'h0000_0011, "istat");
      wr(MCSF_IRQ_STAT_OFS, 32'h0000_0001);
      cyc(3);
      chk("irq_off", 32'h0, {31'h0, irq_o});
      host_ready_request_i <= 1'b0;
      cyc(3);
      chk("ready_drop", 32'h0, {31'h0, processor_ready_o});
      {test_fail_high_i, test_fail_low_i} <= 32'hABCD_1234;
      {test_mode_request_i, test_mode_failed_i} <= 2'b11;
      cyc(1);
      {test_mode_request_i, test_mode_failed_i} <= 2'b00;
      cyc(3);
      rd(MCSF_TEST_ERR_OFS, 32'hABCD_1234, "test_words");
      wr(MCSF_CTRL_OFS, 32'h0000_0002, 4'hE);
      rd(MCSF_FLAGS_OFS, 32'h0000_0E20, "test_err");
      wr(MCSF_CTRL_OFS, 32'h0000_0002);
      watchdog_cause_i <= 16'h00A5;
      watchdog_error_i <= 1'b1;
      cyc(1);
      watchdog_cause_i <= 16'h5A5A;
      cyc(3);
      chk("axes_stop", 32'h1, {31'h0, axes_immediate_stop_o});
      watchdog_error_i <= 1'b0;
      rd(MCSF_WDT_CAUSE_OFS, 32'h0000_00A5, "wdt_cause");
      rd(MCSF_FLAGS_OFS, 32'h0000_8C20, "wdt_flag");
      wr(MCSF_CTRL_OFS, 32'h0000_0004);
      cyc(4);
      chk("axes_free", 32'h0, {31'h0, axes_immediate_stop_o});
      forced_stop_b_i <= 1'b0;
      cyc(9000);
      rd(MCSF_FLAGS_OFS, 32'h0000_2820, "fstop_on");
      forced_stop_b_i <= 1'b1;
      cyc(9000);
      rd(MCSF_FLAGS_OFS, 32'h0000_2C20, "fstop_off");
      wr(MCSF_CTRL_OFS, 32'h0000_0001);
      rd(MCSF_FLAGS_OFS, 32'h0000_0C20, "latch_clr");
      rd(MCSF_IRQ_STAT_OFS, 32'h0000_001E, "istat_end");
      chk("irq_masked", 32'h0, {31'h0, irq_o});
      summarize();
   end
endmodule : tb

// ===== src/mcsf_sync.sv
// three-stage input synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ps
module mcsf_sync (
   input  wire logic   sys_clk_i,
   input  wire logic   rst_b_i,
   mcsf_sync_if.snk    sif
);
   import mcsf_pkg::*;
   logic [MCSF_SYNC_W-1:0] s1_q;
   logic [MCSF_SYNC_W-1:0] s2_q;
   logic [MCSF_SYNC_W-1:0] s3_q;
   logic [MCSF_SYNC_W-1:0] clean_q;
   logic [MCSF_SYNC_W-1:0] clean_d;

   genvar g;
   generate
      for (g = 0; g < MCSF_SYNC_W; g++) begin : g_bit
         assign clean_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : clean_q[g];
      end
   endgenerate

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         s1_q    <= '0;
         s2_q    <= '0;
         s3_q    <= '0;
         clean_q <= '0;
      end else begin
         s1_q    <= sif.raw;
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         clean_q <= clean_d;
      end
   end
   assign sif.clean = clean_q;
endmodule : mcsf_sync

// ===== src/mcsf_top.sv
// motion processor status flag bank with wishbone slave and interrupt
`timescale 1ns/1ps
module mcsf_top (
   input  wire logic         sys_clk_i,
   input  wire logic         rst_b_i,
   // wishbone classic slave
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [7:0]   wb_adr_i,
   input  wire logic [31:0]  wb_dat_i,
   input  wire logic [3:0]   wb_sel_i,
   output logic      [31:0]  wb_dat_o,
   output logic              wb_ack_o,
   output logic              irq_o,
   // multi-cpu and external status, asynchronous
   input  wire logic         cpu4_in_reset_i,
   input  wire logic [3:0]   cpu_stop_error_i,
   input  wire logic         forced_stop_b_i,
   // internal status from the motion processor, same clock
   input  wire logic         host_ready_request_i,
   input  wire logic         param_check_done_i,
   input  wire logic         param_check_error_i,
   input  wire logic         test_mode_request_i,
   input  wire logic         test_mode_established_i,
   input  wire logic         test_mode_failed_i,
   input  wire logic [15:0]  test_fail_low_i,
   input  wire logic [15:0]  test_fail_high_i,
   input  wire logic         scope_running_i,
   input  wire logic         cam_write_op_i,
   input  wire logic         cam_open_area_write_op_i,
   input  wire logic         cam_autogen_op_i,
   input  wire logic         amp_less_mode_i,
   input  wire logic         watchdog_error_i,
   input  wire logic [15:0]  watchdog_cause_i,
   output logic              param_check_start_o,
   output logic              axes_immediate_stop_o,
   output logic              processor_ready_o,
   output logic              multi_cpu_down_o
);
   import mcsf_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // input synchronisers and period enables
   mcsf_sync_if sif ();
   logic [MCSF_SYNC_W-1:0] syn_raw;
   assign syn_raw  = {7'h00, forced_stop_b_i, cpu_stop_error_i, cpu4_in_reset_i};
   assign sif.raw  = syn_raw;

   mcsf_sync u_sync (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b_i),
      .sif       (sif)
   );

   wire       cpu4_rst_s  = sif.clean[0];
   wire [3:0] cpu_err_s   = sif.clean[4:1];
   wire       fstop_rel_s = sif.clean[5];

   logic [15:0] opcyc_cnt_q;
   logic [15:0] main_cnt_q;
   wire  opcyc_en = (opcyc_cnt_q == 16'(MCSF_OPCYC_CYC - 1));
   wire  main_en  = (main_cnt_q  == 16'(MCSF_MAIN_CYC - 1));

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         opcyc_cnt_q <= 16'h0000;
         main_cnt_q  <= 16'h0000;
      end else begin
         opcyc_cnt_q <= opcyc_en ? 16'h0000 : opcyc_cnt_q + 16'h0001;
         main_cnt_q  <= main_en  ? 16'h0000 : main_cnt_q  + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // wishbone decode
   wire wb_req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // writes commit at the edge where the master samples ack, while it still holds the request
   wire wb_wr      = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
   wire wr_ctrl    = wb_wr && (wb_adr_i == MCSF_CTRL_OFS);
   wire wr_istat   = wb_wr && (wb_adr_i == MCSF_IRQ_STAT_OFS);
   wire wr_imask   = wb_wr && (wb_adr_i == MCSF_IRQ_MASK_OFS);
   wire clr_latch  = wr_ctrl && wb_dat_i[MCSF_C_CLR_LATCH];
   wire clr_test   = wr_ctrl && wb_dat_i[MCSF_C_CLR_TEST];
   wire clr_wdt    = wr_ctrl && wb_dat_i[MCSF_C_CLR_WDT];

   ////////////////////////////////////////////////////////////////////////////////
   // status flags
   logic       cpu4_rst_q;
   logic [3:0] cpu_err_q;
   logic       one_q;
   logic       zero_q;
   logic       ready_q;
   logic       test_q;
   logic       test_err_q;
   logic       fstop_in_q;
   logic       scope_q;
   logic       cam_q;
   logic       fstop_lat_q;
   logic       ampless_q;
   logic       wdt_q;
   logic [15:0] test_lo_q;
   logic [15:0] test_hi_q;
   logic [15:0] wdt_cause_q;
   logic       req_prev_q;
   logic       chk_busy_q;
   logic       chk_start_q;
   logic       stop_q;

   wire req_rise = host_ready_request_i && !req_prev_q;
   wire fstop_det = opcyc_en && !fstop_rel_s;
   wire wdt_new   = watchdog_error_i && !wdt_q;
   wire ready_set = chk_busy_q && param_check_done_i && !param_check_error_i && host_ready_request_i;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         cpu4_rst_q  <= 1'b0;
         cpu_err_q   <= 4'h0;
         scope_q     <= 1'b1;
         cam_q       <= 1'b0;
         test_q      <= 1'b0;
      end else begin
         cpu4_rst_q  <= cpu4_rst_s;
         cpu_err_q   <= cpu_err_s;
         scope_q     <= !scope_running_i;
         cam_q       <= cam_write_op_i || cam_open_area_write_op_i || cam_autogen_op_i;
         test_q      <= test_mode_request_i && test_mode_established_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         one_q     <= 1'b1;
         zero_q    <= 1'b0;
         ampless_q <= 1'b0;
      end else if (main_en) begin
         one_q     <= 1'b1;
         zero_q    <= 1'b0;
         ampless_q <= amp_less_mode_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         fstop_in_q <= 1'b1;
      end else if (opcyc_en) begin
         fstop_in_q <= fstop_rel_s;
      end
   end

   // set wins over software clear on the sticky flags
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         fstop_lat_q <= 1'b0;
         test_err_q  <= 1'b0;
         test_lo_q   <= MCSF_WORD_RST;
         test_hi_q   <= MCSF_WORD_RST;
         wdt_q       <= 1'b0;
         wdt_cause_q <= MCSF_WORD_RST;
      end else begin
         fstop_lat_q <= fstop_det || (fstop_lat_q && !clr_latch);
         test_err_q  <= test_mode_failed_i || (test_err_q && !clr_test);
         if (test_mode_failed_i) begin
            test_lo_q <= test_fail_low_i;
            test_hi_q <= test_fail_high_i;
         end
         wdt_q       <= watchdog_error_i || (wdt_q && !clr_wdt);
         if (wdt_new) begin
            wdt_cause_q <= watchdog_cause_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // ready handshake with the host
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         req_prev_q  <= 1'b0;
         chk_busy_q  <= 1'b0;
         chk_start_q <= 1'b0;
         ready_q     <= 1'b0;
      end else begin
         req_prev_q  <= host_ready_request_i;
         chk_start_q <= req_rise;
         if (!host_ready_request_i) begin
            ready_q    <= 1'b0;
            chk_busy_q <= 1'b0;
         end else if (req_rise) begin
            chk_busy_q <= 1'b1;
         end else if (chk_busy_q && param_check_done_i) begin
            ready_q    <= ready_set;
            chk_busy_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         stop_q <= 1'b0;
      end else begin
         stop_q <= watchdog_error_i || wdt_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt status and mask
   logic [MCSF_NIRQ-1:0] istat_q;
   logic [MCSF_NIRQ-1:0] imask_q;
   logic                 irq_q;
   wire  [MCSF_NIRQ-1:0] ievt = {cpu4_rst_s && !cpu4_rst_q, wdt_new,
                                 fstop_det && !fstop_lat_q, test_mode_failed_i, ready_set};
   wire  [MCSF_NIRQ-1:0] iclr = wr_istat ? wb_dat_i[MCSF_NIRQ-1:0] : '0;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         istat_q <= '0;
         imask_q <= '0;
         irq_q   <= 1'b0;
      end else begin
         istat_q <= ievt | (istat_q & ~iclr);
         if (wr_imask) begin
            imask_q <= wb_dat_i[MCSF_NIRQ-1:0];
         end
         irq_q   <= |(istat_q & imask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read mux and answer
   logic [MCSF_NFLAGS-1:0] flags;
   always_comb begin
      flags                   = '0;
      flags[MCSF_B_CPU4_RST]  = cpu4_rst_q;
      flags[MCSF_B_CPU_ERR+:4] = cpu_err_q;
      flags[MCSF_B_ONE]       = one_q;
      flags[MCSF_B_ZERO]      = zero_q;
      flags[MCSF_B_READY]     = ready_q;
      flags[MCSF_B_TEST]      = test_q;
      flags[MCSF_B_TEST_ERR]  = test_err_q;
      flags[MCSF_B_FSTOP_IN]  = fstop_in_q;
      flags[MCSF_B_SCOPE]     = scope_q;
      flags[MCSF_B_CAM]       = cam_q;
      flags[MCSF_B_FSTOP_LAT] = fstop_lat_q;
      flags[MCSF_B_AMPLESS]   = ampless_q;
      flags[MCSF_B_WDT]       = wdt_q;
   end

   logic [31:0] rd_data;
   always_comb begin
      case (wb_adr_i)
         MCSF_FLAGS_OFS:     rd_data = {16'h0000, flags};
         MCSF_CTRL_OFS:      rd_data = 32'h0000_0000;
         MCSF_IRQ_STAT_OFS:  rd_data = {27'h0, istat_q};
         MCSF_IRQ_MASK_OFS:  rd_data = {27'h0, imask_q};
         MCSF_TEST_ERR_OFS:  rd_data = {test_hi_q, test_lo_q};
         MCSF_WDT_CAUSE_OFS: rd_data = {16'h0000, wdt_cause_q};
         MCSF_MULTI_ERR_OFS: rd_data = {16'h0000, cpu4_rst_q ? MCSF_MULTI_DOWN_CODE : 16'h0000};
         default:            rd_data = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_data : 32'h0000_0000;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         param_check_start_o   <= 1'b0;
         axes_immediate_stop_o <= 1'b0;
         processor_ready_o     <= 1'b0;
         multi_cpu_down_o      <= 1'b0;
      end else begin
         param_check_start_o   <= chk_start_q;
         axes_immediate_stop_o <= stop_q;
         processor_ready_o     <= ready_q;
         multi_cpu_down_o      <= cpu4_rst_q;
      end
   end
   assign irq_o = irq_q;
endmodule : mcsf_top
